// ==== hw/axil_rw_slave.sv ====
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: Master keeps valid and payload stable until taken
// Notes:   Register decode is left to the parent

`timescale 1ns/100ps

module axil_rw_slave
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output      logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output      logic        wready,
    output      logic [1:0]  bresp,
    output      logic        bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output      logic        arready,
    output      logic [31:0] rdata,
    output      logic [1:0]  rresp,
    output      logic        rvalid,
    input  wire logic        rready,
    output      logic        wr_go,      // One-cycle write commit
    output      logic [7:0]  wr_addr,
    output      logic [31:0] wr_data,
    output      logic [3:0]  wr_strb,
    input  wire logic [1:0]  wr_resp,
    output      logic [7:0]  rd_addr,    // Read address, combinational
    output      logic        rd_go,      // One-cycle read capture
    input  wire logic [31:0] rd_data,
    input  wire logic [1:0]  rd_resp
);

    // ------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------
    logic        aw_have_r;   // Address held
    logic        w_have_r;    // Data held
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;

    assign awready = !aw_have_r && !bvalid_r;
    assign wready  = !w_have_r && !bvalid_r;
    wire   aw_take = awvalid && awready;
    wire   w_take  = wvalid && wready;
    wire   aw_ok   = aw_have_r || aw_take;
    wire   w_ok    = w_have_r || w_take;
    assign wr_go   = aw_ok && w_ok && !bvalid_r;
    assign wr_addr = aw_have_r ? awaddr_r : awaddr;
    assign wr_data = w_have_r ? wdata_r : wdata;
    assign wr_strb = w_have_r ? wstrb_r : wstrb;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;

    // Address and data in either order, response after both
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'h0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
        end
        else if (wr_go)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_resp;
        end
        else
        begin
            if (aw_take)
            begin
                aw_have_r <= 1'b1;
                awaddr_r  <= awaddr;
            end
            if (w_take)
            begin
                w_have_r <= 1'b1;
                wdata_r  <= wdata;
                wstrb_r  <= wstrb;
            end
            if (bvalid_r && bready)
                bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    assign arready = !rvalid_r;
    assign rd_go   = arvalid && arready;
    assign rd_addr = araddr;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    // Data registered at the edge that takes the address, valid the cycle after
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= 2'h0;
        end
        else if (rd_go)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_data;
            rresp_r  <= rd_resp;
        end
        else if (rvalid_r && rready)
            rvalid_r <= 1'b0;
    end

endmodule : axil_rw_slave

// ==== hw/seq_limit_pkg.sv ====
// Purpose: Shared constants and carrier types for the sequencer timer limit block
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz aclk
// Notes:   Offsets are byte addresses of aligned words

package seq_limit_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_TIMER0_LIMIT = 8'h00;  // Timer 0 limit
    localparam logic [7:0]  OFS_TIMER1_LIMIT = 8'h04;  // Timer 1 limit
    localparam logic [7:0]  OFS_CONTROL      = 8'h08;  // Enable and start bits
    localparam logic [7:0]  OFS_STATUS       = 8'h0C;  // Step and counter state

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          CTRL_ENABLE_BIT  = 0;      // Sequencer enable
    localparam int          CTRL_START_BIT   = 1;      // Sequencer start
    localparam logic [15:0] LIMIT_RESET      = 16'h0000;
    localparam int          STAT_BUSY_BIT    = 0;      // Step in progress
    localparam int          STAT_SEL_BIT     = 1;      // Timer of current step
    localparam int          STAT_DONE_BIT    = 2;      // Last step finished
    localparam int          STAT_COUNT_LSB   = 16;     // Counter value field

    // ------------------------------------------------------------
    // AXI response codes
    // ------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;   // Step command issued this cycle
        logic        sel;     // 0 = timer 0 step, 1 = timer 1 step
    } step_cmd_t;

    typedef struct packed {
        logic        busy;    // Step in progress
        logic        sel;     // Timer of current step
        logic        done;    // One-cycle end of step
        logic [15:0] count;   // Current count
    } step_stat_t;

    // Byte-enable merge of a write into a 16-bit limit
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  ws);
        merge16 = old_v;
        if (ws[0]) merge16[7:0]  = wd[7:0];
        if (ws[1]) merge16[15:8] = wd[15:8];
    endfunction : merge16

endpackage : seq_limit_pkg

// ==== hw/seq_step_timer.sv ====
// Purpose: Counter that runs one timer step against the selected limit
// Assumes: Step commands arrive from the sequencer's command decoder
// Notes:   A new command during a step is ignored until that step ends

`timescale 1ns/100ps

module seq_step_timer
    import seq_limit_pkg::*;
(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire seq_limit_pkg::step_cmd_t cmd,
    input  wire logic [15:0]              limit0,
    input  wire logic [15:0]              limit1,
    output      seq_limit_pkg::step_stat_t stat
);
    import seq_limit_pkg::*;

    // ------------------------------------------------------------
    // Step state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {ST_IDLE, ST_RUN} step_state_t;

    step_state_t state_r;        // Idle or counting
    logic        sel_r;          // Timer of the running step
    logic [15:0] count_r;        // Running count
    logic        done_r;         // End-of-step pulse

    // Only the addressed timer's limit is ever looked at
    wire  [15:0] active_limit = sel_r ? limit1 : limit0;
    wire         at_limit     = (count_r == active_limit);

    // Counter from zero to the limit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= ST_IDLE;
            sel_r   <= 1'b0;
            count_r <= 16'h0000;
            done_r  <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (cmd.valid)
                    begin
                        state_r <= ST_RUN;
                        sel_r   <= cmd.sel;
                        count_r <= 16'h0000;
                    end
                end
                ST_RUN:
                begin
                    if (at_limit)
                    begin
                        state_r <= ST_IDLE;
                        done_r  <= 1'b1;
                    end
                    else
                        count_r <= count_r + 16'h0001;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign stat = '{busy: (state_r == ST_RUN), sel: sel_r, done: done_r, count: count_r};

    // Step ends exactly when the count reaches the limit
    step_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_r == ST_RUN && at_limit) |=> done_r && state_r == ST_IDLE)
        else $error("step did not end at limit");

    // Counting starts at zero
    step_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_r == ST_IDLE && cmd.valid) |=> count_r == 16'h0000)
        else $error("step count did not start at zero");

endmodule : seq_step_timer

// ==== hw/sequencer_timer_limit_regs.sv ====
// Purpose: Timer limit registers of the trigger sequencer with step timer
// Assumes: Step commands come from the sequencer command decoder
// Notes:   Limits lock while the sequencer is enabled and started
//
// Behaviour
// - Timer 0 limit, 16 bits, resets zero
// - Timer 0 limit used only by its step
// - Timer 1 limit, 16 bits, resets zero
// - Timer 1 limit used only by its step
// - Enable and start set: limits ignore writes
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.

`timescale 1ns/100ps

module sequencer_timer_limit_regs
    import seq_limit_pkg::*;
(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output      logic                     s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output      logic                     s_axi_wready,
    output      logic [1:0]               s_axi_bresp,
    output      logic                     s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output      logic                     s_axi_arready,
    output      logic [31:0]              s_axi_rdata,
    output      logic [1:0]               s_axi_rresp,
    output      logic                     s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire seq_limit_pkg::step_cmd_t step_cmd,
    output      seq_limit_pkg::step_stat_t step_stat,
    output      logic                     sequencer_enable_bit,
    output      logic                     sequencer_start_bit,
    output      logic [15:0]              seq_timer0_limit,
    output      logic [15:0]              seq_timer1_limit
);
    import seq_limit_pkg::*;

    // ------------------------------------------------------------
    // Bus front end hookup
    // ------------------------------------------------------------
    logic        wr_go;       // Write commit pulse
    logic [7:0]  wr_addr;     // Write address
    logic [31:0] wr_data;     // Write data
    logic [3:0]  wr_strb;     // Write strobes
    logic [7:0]  rd_addr;     // Read address
    logic        rd_go;       // Read capture pulse
    logic [31:0] rd_data;     // Decoded read word
    logic [1:0]  rd_resp;     // Read answer
    logic [1:0]  wr_resp;     // Write answer

    axil_rw_slave axil_rw_slave_inst
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_go   (wr_go),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_resp (wr_resp),
        .rd_addr (rd_addr),
        .rd_go   (rd_go),
        .rd_data (rd_data),
        .rd_resp (rd_resp)
    );

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [15:0] limit0_r;    // Timer 0 limit
    logic [15:0] limit1_r;    // Timer 1 limit
    logic        enable_r;    // Sequencer enable
    logic        start_r;     // Sequencer start
    logic [15:0] limit0_nxt;
    logic [15:0] limit1_nxt;

    // Write address decode
    wire wsel_lim0 = (wr_addr == OFS_TIMER0_LIMIT);
    wire wsel_lim1 = (wr_addr == OFS_TIMER1_LIMIT);
    wire wsel_ctrl = (wr_addr == OFS_CONTROL);
    wire wsel_stat = (wr_addr == OFS_STATUS);
    wire wsel_any  = wsel_lim0 || wsel_lim1 || wsel_ctrl || wsel_stat;

    // Lock while running; a locked write still answers OKAY, like a read-only bit
    wire limits_locked = enable_r && start_r;
    wire lim0_we       = wr_go && wsel_lim0 && !limits_locked;
    wire lim1_we       = wr_go && wsel_lim1 && !limits_locked;
    wire ctrl_we       = wr_go && wsel_ctrl && wr_strb[0];

    assign wr_resp    = wsel_any ? RESP_OKAY : RESP_SLVERR;
    assign limit0_nxt = merge16(limit0_r, wr_data, wr_strb);
    assign limit1_nxt = merge16(limit1_r, wr_data, wr_strb);

    // Limit registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            limit0_r <= LIMIT_RESET;
            limit1_r <= LIMIT_RESET;
        end
        else
        begin
            if (lim0_we)
                limit0_r <= limit0_nxt;
            if (lim1_we)
                limit1_r <= limit1_nxt;
        end
    end

    // Control bits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            enable_r <= 1'b0;
            start_r  <= 1'b0;
        end
        else if (ctrl_we)
        begin
            enable_r <= wr_data[CTRL_ENABLE_BIT];
            start_r  <= wr_data[CTRL_START_BIT];
        end
    end

    // ------------------------------------------------------------
    // Step timer
    // ------------------------------------------------------------
    // Commands count only while the sequencer is enabled and started
    step_cmd_t  gated_cmd;
    step_stat_t stat_w;

    assign gated_cmd = '{valid: step_cmd.valid && limits_locked, sel: step_cmd.sel};

    seq_step_timer seq_step_timer_inst
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .cmd     (gated_cmd),
        .limit0  (limit0_r),
        .limit1  (limit1_r),
        .stat    (stat_w)
    );

    // Sticky done flag; a new step start clears it, the end pulse wins
    logic done_seen_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            done_seen_r <= 1'b0;
        else if (stat_w.done)
            done_seen_r <= 1'b1;
        else if (gated_cmd.valid && !stat_w.busy)
            done_seen_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    wire [31:0] rd_ctrl = {30'h00000000, start_r, enable_r};
    wire [31:0] rd_stat = {stat_w.count, 13'h0000, done_seen_r, stat_w.sel, stat_w.busy};

    assign rd_data = (rd_addr == OFS_TIMER0_LIMIT) ? {16'h0000, limit0_r} :
                     (rd_addr == OFS_TIMER1_LIMIT) ? {16'h0000, limit1_r} :
                     (rd_addr == OFS_CONTROL)      ? rd_ctrl :
                     (rd_addr == OFS_STATUS)       ? rd_stat : 32'h00000000;
    assign rd_resp = ((rd_addr == OFS_TIMER0_LIMIT) || (rd_addr == OFS_TIMER1_LIMIT) ||
                      (rd_addr == OFS_CONTROL) || (rd_addr == OFS_STATUS))
                     ? RESP_OKAY : RESP_SLVERR;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign step_stat            = stat_w;
    assign sequencer_enable_bit = enable_r;
    assign sequencer_start_bit  = start_r;
    assign seq_timer0_limit     = limit0_r;
    assign seq_timer1_limit     = limit1_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    lim0_locked_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (enable_r && start_r) |=> $stable(limit0_r) || !$past(enable_r && start_r))
        else $error("timer 0 limit changed while locked");

    lim1_locked_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (enable_r && start_r) |=> $stable(limit1_r))
        else $error("timer 1 limit changed while locked");

    lim0_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && wsel_lim0 && !limits_locked && wr_strb[1:0] == 2'h3)
        |=> limit0_r == $past(wr_data[15:0]))
        else $error("timer 0 limit write lost");

    lim1_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && wsel_lim1 && !limits_locked && wr_strb[1:0] == 2'h3)
        |=> limit1_r == $past(wr_data[15:0]))
        else $error("timer 1 limit write lost");

    lim0_other_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(wr_go && wsel_lim0) |=> $stable(limit0_r))
        else $error("timer 0 limit changed without write");

    lim1_other_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(wr_go && wsel_lim1) |=> $stable(limit1_r))
        else $error("timer 1 limit changed without write");

    step0_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (stat_w.busy && !stat_w.sel && stat_w.count == limit0_r) |=> stat_w.done)
        else $error("timer 0 step ignored its limit");

    step1_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (stat_w.busy && stat_w.sel && stat_w.count == limit1_r) |=> stat_w.done)
        else $error("timer 1 step ignored its limit");

endmodule : sequencer_timer_limit_regs

// ==== tb/tb_sequencer_timer_limit_regs.sv ====
// Purpose: Self-checking bench for the sequencer timer limit block
// Assumes: AXI4-Lite master drives on rising edges, one transfer at a time
// Notes:   Answers are sampled at the falling edge, where outputs have settled
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_sequencer_timer_limit_regs;
    import seq_limit_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic        aclk, aresetn;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    step_cmd_t   step_cmd;       // Command pulse toward the step timer
    step_stat_t  step_stat;      // Step progress as seen by the decoder
    logic        en_bit, st_bit;
    logic [15:0] lim0, lim1;
    int          err_total, checks_done;
    int          nb;             // Busy cycles of the last step
    logic [15:0] first;          // Count in the first busy cycle

    sequencer_timer_limit_regs sequencer_timer_limit_regs_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .step_cmd(step_cmd),
        .step_stat(step_stat), .sequencer_enable_bit(en_bit),
        .sequencer_start_bit(st_bit), .seq_timer0_limit(lim0), .seq_timer1_limit(lim1));

    // ----------------------------------------------------------------
    // Clock, 50 ns period
    // ----------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Verdict and end of run, shared with the watchdog
    task wrap_up;
        $display("Checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // Write: both channels offered together, each dropped once taken
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                input logic [1:0] er);
        logic aw_hs, w_hs, b_hs;
        logic [1:0] resp;
        b_hs = 1'b0;
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
        for (int n = 0; n < 50 && !b_hs; n++)
        begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs  = wvalid && wready;
            b_hs  = bvalid && bready;
            resp  = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs)  wvalid  <= 1'b0;
            if (b_hs)  bready  <= 1'b0;
        end
        `CHK(b_hs, 1'b1)
        `CHK(resp, er)
    endtask : axi_wr

    // Read: rready held until rvalid, data taken at that edge
    task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_hs, r_hs;
        logic [31:0] d;
        logic [1:0]  resp;
        r_hs = 1'b0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int n = 0; n < 50 && !r_hs; n++)
        begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs  = rvalid && rready;
            d     = rdata;
            resp  = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs)  rready  <= 1'b0;
        end
        `CHK(r_hs, 1'b1)
        `CHK(d, ed)
        `CHK(resp, er)
    endtask : axi_rd

    // One command pulse, then busy cycles counted until done or 40 cycles
    task step_run(input logic s);
        logic done_seen;
        done_seen = 1'b0;
        nb = 0;
        first = 16'hFFFF;
        step_cmd <= '{valid: 1'b1, sel: s};
        @(posedge aclk);
        step_cmd <= '{valid: 1'b0, sel: s};
        for (int i = 0; i < 40 && !done_seen; i++)
        begin
            @(negedge aclk);
            if (step_stat.busy === 1'b1)
            begin
                if (nb == 0) first = step_stat.count;
                nb++;
            end
            if (step_stat.done === 1'b1) done_seen = 1'b1;
            @(posedge aclk);
        end
    endtask : step_run

    // ----------------------------------------------------------------
    // Watchdog: the whole sequence needs well under 1000 cycles
    // ----------------------------------------------------------------
    initial
    begin
        #100us;
        err_total++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        err_total = 0; checks_done = 0; aresetn = 1'b0;
        awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0;
        bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0; step_cmd = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values and byte lanes
        axi_rd(OFS_TIMER0_LIMIT, 32'h0, RESP_OKAY);
        axi_rd(OFS_TIMER1_LIMIT, 32'h0, RESP_OKAY);
        axi_wr(OFS_TIMER0_LIMIT, 32'h1234ABCD, 4'hF, RESP_OKAY);
        axi_rd(OFS_TIMER0_LIMIT, 32'h0000ABCD, RESP_OKAY);
        axi_wr(OFS_TIMER0_LIMIT, 32'h0000FF00, 4'h2, RESP_OKAY);
        axi_rd(OFS_TIMER0_LIMIT, 32'h0000FFCD, RESP_OKAY);
        axi_wr(OFS_TIMER1_LIMIT, 32'hFFFF5A5A, 4'hF, RESP_OKAY);
        axi_rd(OFS_TIMER1_LIMIT, 32'h00005A5A, RESP_OKAY);
        // Unmapped place answers with an error
        axi_wr(8'h10, 32'h1, 4'hF, RESP_SLVERR);
        axi_rd(8'h10, 32'h0, RESP_SLVERR);
        // Step ignored while the sequencer is stopped
        step_run(1'b0);
        `CHK(nb, 0)
        // Enable alone does not lock the limits
        axi_wr(OFS_CONTROL, 32'h1, 4'hF, RESP_OKAY);
        axi_wr(OFS_TIMER0_LIMIT, 32'h5, 4'hF, RESP_OKAY);
        axi_rd(OFS_TIMER0_LIMIT, 32'h5, RESP_OKAY);
        axi_wr(OFS_TIMER0_LIMIT, 32'h2, 4'hF, RESP_OKAY);
        axi_wr(OFS_TIMER1_LIMIT, 32'h3, 4'hF, RESP_OKAY);
        // Enable and start: writes are accepted but ignored
        axi_wr(OFS_CONTROL, 32'h3, 4'hF, RESP_OKAY);
        axi_rd(OFS_CONTROL, 32'h3, RESP_OKAY);
        `CHK({st_bit, en_bit}, 2'h3)
        axi_wr(OFS_TIMER0_LIMIT, 32'hFFFF, 4'hF, RESP_OKAY);
        axi_rd(OFS_TIMER0_LIMIT, 32'h2, RESP_OKAY);
        axi_wr(OFS_TIMER1_LIMIT, 32'hFFFF, 4'hF, RESP_OKAY);
        `CHK(lim1, 16'h0003)
        // Different limits show which one each step uses
        step_run(1'b0);
        `CHK(nb, 3)
        `CHK(first, 16'h0000)
        step_run(1'b1);
        `CHK(nb, 4)
        `CHK(first, 16'h0000)
        // Status: count held at limit 3, sticky done, timer 1, idle
        axi_rd(OFS_STATUS, 32'h00030006, RESP_OKAY);
        `CHK(step_stat.busy, 1'b0)
        // Lock lifts once the sequencer stops
        axi_wr(OFS_CONTROL, 32'h0, 4'hF, RESP_OKAY);
        axi_wr(OFS_TIMER0_LIMIT, 32'h7, 4'hF, RESP_OKAY);
        `CHK(lim0, 16'h0007)
        wrap_up();
    end
endmodule : tb_sequencer_timer_limit_regs
